/* File: rte_defs.svh */
// What this block does
// [RQ1] start tests only while emulation paused
// [RQ2] mismatch flags failure with address, expected, observed
// [RQ3] simple pass success signals once, stops
// [RQ4] function 1: sequenced pattern write, read, once
// [RQ5] complete test failure carries step number
// [RQ6] function 2: loop simple test, count passes
// [RQ7] looping simple: report failure, continue next pass
// [RQ8] function 3: loop complete sequenced pattern
// [RQ9] looping complete: full report then continue
// [RQ10] looping tests end only on reset request
// [RQ11] sixteen-bit pass counter, zero first, wraps
// [RQ12] each bus cycle completes before next
`ifndef RTE_DEFS_SVH
`define RTE_DEFS_SVH
// ----------------------------------------
// widths and command codes
// ----------------------------------------
`define RTE_AW 20
`define RTE_DW 16
`define RTE_SW 8
`define RTE_PW 16
`define RTE_FN_SIMPLE 2'h0
`define RTE_FN_COMPLETE 2'h1
`define RTE_FN_SIMPLE_LOOP 2'h2
`define RTE_FN_COMPLETE_LOOP 2'h3
// walking-bit steps: 2 * data width
`define RTE_SIMPLE_STEPS 8'h20
// complete sequence: 4 march steps
`define RTE_COMPLETE_STEPS 8'h04
`endif

/* File: rte_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rte_defs.svh"
module rte_engine
    import rte_pkg::*;
(
    input wire logic MCLK, // 20 MHz clock
    input wire logic SRST, // sync reset, high
    input wire logic PAUSED, // emulation paused
    input wire logic START, // start pulse
    input wire logic [1:0] DIAG_FUNCTION_CMD, // function 0..3
    input wire logic [`RTE_AW-1:0] RANGE_LO, // first address
    input wire logic [`RTE_AW-1:0] RANGE_HI, // last address
    input wire logic RESET_REQ, // host terminate request
    output logic REFUSED, // start refused pulse
    output logic BUSY, // test running
    output logic [`RTE_AW-1:0] MEM_ADDR, // target address
    output logic [`RTE_DW-1:0] MEM_WDATA, // target write data
    output logic MEM_WE, // write when high
    output logic MEM_REQ, // cycle request
    input wire logic MEM_ACK, // cycle done
    input wire logic [`RTE_DW-1:0] MEM_RDATA, // read data
    output logic FAIL, // failure pulse
    output logic [`RTE_AW-1:0] FAIL_ADDR, // failing address
    output logic [`RTE_DW-1:0] FAIL_GOOD, // expected data
    output logic [`RTE_DW-1:0] FAIL_BAD, // observed data
    output logic [`RTE_SW-1:0] FAIL_SEQ, // step number
    output logic DONE_OK, // clean finish pulse
    output logic PASS_STB, // pass ended pulse
    output logic [`RTE_PW-1:0] PASS_COUNT // pass counter
);
    // ----------------------------------------
    // pattern generation
    // ----------------------------------------
    // walking pattern: ones shift in, then shift out
    function automatic logic [`RTE_DW-1:0] walk_pat(input logic [`RTE_SW-1:0] s);
        logic [`RTE_DW-1:0] ones;
        ones = {`RTE_DW{1'b1}};
        if (s < `RTE_DW) begin
            walk_pat = ~(ones >> (s + 8'h01));
        end else begin
            // second half: step 16 holds all ones, the last step keeps only bit 0
            // so bit 0 stays high through the whole second half
            walk_pat = ones >> (s - 8'h10);
        end
    endfunction : walk_pat
    // complete sequence: zeros, ones, alternating, inverse
    function automatic logic [`RTE_DW-1:0] seq_pat(input logic [`RTE_SW-1:0] s);
        case (s[1:0])
            2'h0: seq_pat = 16'h0000;
            2'h1: seq_pat = 16'hFFFF;
            2'h2: seq_pat = 16'h5555;
            default: seq_pat = 16'hAAAA;
        endcase
    endfunction : seq_pat

    rte_state_e state; // engine phase
    logic [1:0] func; // latched function
    logic [`RTE_AW-1:0] addr; // current address
    logic [`RTE_SW-1:0] step; // pattern step
    logic pass_fail; // mismatch seen this pass
    logic [`RTE_DW-1:0] exp_data; // expected value
    logic [`RTE_DW-1:0] rd_data; // captured read
    logic complete; // complete pattern family
    logic looping; // looping function
    logic [`RTE_SW-1:0] last_step; // final step index
    logic pass_end; // last check of the last step is behind us

    // ----------------------------------------
    // decode and bus outputs
    // ----------------------------------------
    // function code bit 0 picks the pattern family, bit 1 loops
    assign complete = func[0];
    assign looping = func[1];
    assign last_step = complete ? (`RTE_COMPLETE_STEPS - 8'h01) : (`RTE_SIMPLE_STEPS - 8'h01);
    assign pass_end = (state == RTE_NEXT) && (step == last_step);
    assign exp_data = complete ? seq_pat(step) : walk_pat(step);
    assign BUSY = (state != RTE_IDLE);
    assign MEM_ADDR = addr;
    assign MEM_WDATA = exp_data;
    assign MEM_WE = (state == RTE_WRITE);
    assign MEM_REQ = (state == RTE_WRITE) || (state == RTE_READ);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // each step writes the whole range then reads it back
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= RTE_IDLE;
            func <= 2'h0;
            addr <= '0;
            step <= '0;
            rd_data <= '0;
        // [RQ10] terminate on reset
        end else if (RESET_REQ) begin
            state <= RTE_IDLE;
        end else begin
            case (state)
                RTE_IDLE: begin
                    // [RQ1] paused-only start
                    if (START && PAUSED) begin
                        func <= DIAG_FUNCTION_CMD;
                        addr <= RANGE_LO;
                        step <= '0;
                        state <= RTE_WRITE;
                    end
                end
                // [RQ12] wait for handshake
                RTE_WRITE: begin
                    // a reversed range wraps past the top of the address space to address 0
                    if (MEM_ACK) begin
                        if (addr == RANGE_HI) begin
                            addr <= RANGE_LO;
                            state <= RTE_READ;
                        end else begin
                            addr <= addr + 1'b1;
                        end
                    end
                end
                // read data is only valid with the ack, so take it there
                RTE_READ: begin
                    if (MEM_ACK) begin
                        rd_data <= MEM_RDATA;
                        state <= RTE_CHECK;
                    end
                end
                // one idle bus cycle per compare keeps the report in step
                RTE_CHECK: begin
                    if (addr == RANGE_HI) begin
                        state <= RTE_NEXT;
                    end else begin
                        addr <= addr + 1'b1;
                        state <= RTE_READ;
                    end
                end
                RTE_NEXT: begin
                    addr <= RANGE_LO;
                    // [RQ4] all steps of pattern
                    if (step != last_step) begin
                        step <= step + 8'h01;
                        state <= RTE_WRITE;
                    // [RQ6] [RQ8] loop again
                    end else if (looping) begin
                        step <= '0;
                        state <= RTE_WRITE;
                    end else begin
                        // [RQ3] single pass stops
                        state <= RTE_IDLE;
                    end
                end
                default: state <= RTE_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // failure report
    // ----------------------------------------
    // report regs hold until the next failure
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            FAIL <= 1'b0;
            FAIL_ADDR <= '0;
            FAIL_GOOD <= '0;
            FAIL_BAD <= '0;
            FAIL_SEQ <= '0;
            pass_fail <= 1'b0;
        end else begin
            FAIL <= 1'b0;
            if (state == RTE_IDLE || pass_end) begin
                pass_fail <= 1'b0;
            end
            // [RQ2] compare and report
            if (state == RTE_CHECK && rd_data != exp_data && !RESET_REQ) begin
                FAIL <= 1'b1;
                FAIL_ADDR <= addr;
                FAIL_GOOD <= exp_data;
                FAIL_BAD <= rd_data;
                // [RQ5] [RQ9] step number
                FAIL_SEQ <= complete ? step + 8'h01 : 8'h00;
                pass_fail <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // completion and pass count
    // ----------------------------------------
    // failures are reported before the pass strobe of that pass
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            DONE_OK <= 1'b0;
            PASS_STB <= 1'b0;
            PASS_COUNT <= '0;
            REFUSED <= 1'b0;
        end else begin
            DONE_OK <= 1'b0;
            PASS_STB <= 1'b0;
            // a start while busy is ignored without a pulse
            REFUSED <= (state == RTE_IDLE) && START && !PAUSED;
            // [RQ11] clear at start
            if (state == RTE_IDLE && START && PAUSED) begin
                PASS_COUNT <= '0;
            end
            if (pass_end && !RESET_REQ) begin
                // [RQ3] success once
                if (!looping && !pass_fail) begin
                    DONE_OK <= 1'b1;
                end
                // [RQ7] report then continue
                if (looping) begin
                    PASS_STB <= 1'b1;
                end
            end
            // [RQ11] count after strobe, wraps
            if (PASS_STB) begin
                PASS_COUNT <= PASS_COUNT + 16'h0001;
            end
        end
    end
endmodule : rte_engine
`default_nettype wire

/* File: rte_pkg.sv */
`default_nettype none
`include "rte_defs.svh"
package rte_pkg;
    // engine phases
    typedef enum logic [2:0] {RTE_IDLE, RTE_WRITE, RTE_READ, RTE_CHECK, RTE_NEXT} rte_state_e;
endpackage : rte_pkg
`default_nettype wire

/* File: rte_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rte_defs.svh"
// ----------------------------------------
// engine port checks
// ----------------------------------------
module rte_props (
    input wire logic MCLK, // clk
    input wire logic SRST, // rst
    input wire logic PAUSED, // paused
    input wire logic START, // go
    input wire logic RESET_REQ, // abort
    input wire logic REFUSED, // refused
    input wire logic BUSY, // busy
    input wire logic [`RTE_AW-1:0] MEM_ADDR, // addr
    input wire logic [`RTE_DW-1:0] MEM_WDATA, // wdata
    input wire logic MEM_WE, // write
    input wire logic MEM_REQ, // req
    input wire logic MEM_ACK, // ack
    input wire logic [`RTE_AW-1:0] RANGE_LO, // first
    input wire logic FAIL, // fail
    input wire logic [`RTE_DW-1:0] FAIL_GOOD, // expected
    input wire logic [`RTE_DW-1:0] FAIL_BAD, // seen
    input wire logic [`RTE_SW-1:0] FAIL_SEQ, // step
    input wire logic DONE_OK, // done
    input wire logic PASS_STB, // pass end
    input wire logic [`RTE_PW-1:0] PASS_COUNT // count
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    logic rd_take; // read taken one cycle ago
    // delayed read handshake, a failure must trace back to one
    always_ff @(posedge MCLK) begin
        rd_take <= MEM_REQ && MEM_ACK && !MEM_WE && !SRST;
    end
    sequence s_go; !BUSY && START && PAUSED && !RESET_REQ; endsequence
    sequence s_wait; MEM_REQ && !MEM_ACK && !RESET_REQ; endsequence
    sequence s_nogo; !BUSY && START && !PAUSED && !RESET_REQ; endsequence
    sequence s_first; BUSY && MEM_REQ && MEM_WE && MEM_ADDR == RANGE_LO; endsequence
    sequence s_hold;
        MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA);
    endsequence
    sequence s_count; PASS_COUNT == 16'($past(PASS_COUNT) + 16'h1); endsequence
    a_refuse_unpaused: assert property (s_nogo |=> REFUSED)
        else $error("start while not paused not refused");
    a_stay_idle: assert property (!BUSY && !PAUSED |=> !BUSY)
        else $error("test began while not paused");
    a_start_write: assert property (s_go |=> s_first)
        else $error("test did not open with a write at the low address");
    a_cycle_held: assert property (s_wait |=> s_hold)
        else $error("memory cycle dropped before ack");
    a_fail_read: assert property (FAIL |-> $past(rd_take) && FAIL_GOOD != FAIL_BAD)
        else $error("failure without a mismatching read");
    a_fail_step: assert property (FAIL |-> FAIL_SEQ <= 8'h04)
        else $error("step number out of range");
    a_done_stops: assert property (DONE_OK |=> (!MEM_REQ && !DONE_OK) [*4])
        else $error("single pass repeated after success");
    a_count_step: assert property (PASS_STB && !RESET_REQ |=> s_count)
        else $error("pass count did not advance by one");
    a_reset_ends: assert property (RESET_REQ |=> !BUSY && !MEM_REQ)
        else $error("abort request did not stop the test");
endmodule : rte_props
bind rte_engine rte_props rte_props_inst (.MCLK(MCLK), .SRST(SRST), .PAUSED(PAUSED),
    .START(START), .RESET_REQ(RESET_REQ), .REFUSED(REFUSED), .BUSY(BUSY), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
    .RANGE_LO(RANGE_LO), .FAIL(FAIL), .FAIL_GOOD(FAIL_GOOD), .FAIL_BAD(FAIL_BAD),
    .FAIL_SEQ(FAIL_SEQ), .DONE_OK(DONE_OK), .PASS_STB(PASS_STB), .PASS_COUNT(PASS_COUNT));
`default_nettype wire

/* File: rte_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rte_defs.svh"
// ----------------------------------------
// target memory, prompt or slow ack
// ----------------------------------------
module rte_ram_model (
    input wire logic MCLK, // clk
    input wire logic SRST, // rst
    input wire logic MEM_REQ, // req
    input wire logic MEM_WE, // write
    input wire logic [`RTE_AW-1:0] MEM_ADDR, // addr
    input wire logic [`RTE_DW-1:0] MEM_WDATA, // wdata
    input wire logic stuck, // bit 0 of word 2 reads one
    output logic MEM_ACK, // ack pulse
    output logic [`RTE_DW-1:0] MEM_RDATA // read data
);
    logic [`RTE_DW-1:0] mem [8]; // small window, address wraps
    logic [1:0] tick; // free count that varies the ack delay
    always @(posedge MCLK) begin
        tick <= SRST ? 2'h0 : tick + 2'h1;
        MEM_ACK <= !SRST && MEM_REQ && !MEM_ACK && tick != 2'h0;
        if (MEM_REQ && MEM_ACK && MEM_WE) mem[MEM_ADDR[2:0]] <= MEM_WDATA;
        // outside an answer the data lines toggle, so stale data never matches
        if (MEM_REQ && !MEM_ACK && tick != 2'h0 && !MEM_WE)
            MEM_RDATA <= mem[MEM_ADDR[2:0]] | {15'h0, stuck && MEM_ADDR[2:0] == 3'h2};
        else MEM_RDATA <= SRST ? 16'h0 : ~MEM_RDATA;
    end
endmodule : rte_ram_model
`default_nettype wire

/* File: target_ram_test_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rte_defs.svh"
// ----------------------------------------
// engine bench
// ----------------------------------------
module target_ram_test_engine_bench;
    logic MCLK = 0, SRST = 1, PAUSED = 1, START = 0, RESET_REQ = 0, stuck = 0; // drives
    logic [1:0] fn = 0; // function code
    logic [`RTE_AW-1:0] lo = 0, hi = 1, a, fa; // range, bus and fail address
    logic [`RTE_DW-1:0] wd, rd, fg, fb; // data
    logic REFUSED, BUSY, we, req, ack, FAIL, DONE_OK, PASS_STB; // flags
    logic [`RTE_SW-1:0] fs; // step
    logic [`RTE_PW-1:0] pc; // pass count
    int err_total = 0, total_checks = 0, cyc = 0, nf = 0, nd = 0, ns = 0; // tallies
    initial forever #25 MCLK = ~MCLK;
    rte_engine rte_engine_inst (.MCLK(MCLK), .SRST(SRST), .PAUSED(PAUSED), .START(START),
        .DIAG_FUNCTION_CMD(fn), .RANGE_LO(lo), .RANGE_HI(hi), .RESET_REQ(RESET_REQ),
        .REFUSED(REFUSED), .BUSY(BUSY), .MEM_ADDR(a), .MEM_WDATA(wd), .MEM_WE(we),
        .MEM_REQ(req), .MEM_ACK(ack), .MEM_RDATA(rd), .FAIL(FAIL), .FAIL_ADDR(fa),
        .FAIL_GOOD(fg), .FAIL_BAD(fb), .FAIL_SEQ(fs), .DONE_OK(DONE_OK),
        .PASS_STB(PASS_STB), .PASS_COUNT(pc));
    rte_ram_model rte_ram_model_inst (.MCLK(MCLK), .SRST(SRST), .MEM_REQ(req), .MEM_WE(we),
        .MEM_ADDR(a), .MEM_WDATA(wd), .stuck(stuck), .MEM_ACK(ack), .MEM_RDATA(rd));
    // pulse tallies and the hang limit
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        nf <= nf + FAIL;
        nd <= nd + DONE_OK;
        ns <= ns + PASS_STB;
        if (cyc == 60000) begin
            err_total++;
            give_verdict;
        end
    end
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    // start pulse, tallies cleared clear of the edge
    task go(input logic [1:0] f);
        @(posedge MCLK);
        START <= 1;
        fn <= f;
        hi <= 2;
        @(posedge MCLK);
        START <= 0;
        #1;
        {nf, nd, ns} = 0;
    endtask : go
    task t_refuse;
        PAUSED <= 0;
        go(2'h0);
        chk("refused", REFUSED, 1);
        chk("busy", BUSY, 0);
        @(posedge MCLK);
        PAUSED <= 1;
        $display("test refuse done");
    endtask : t_refuse
    task t_once(input logic [1:0] f, input logic s, input int k, input logic [15:0] g, b,
        input logic [7:0] q);
        stuck <= s;
        go(f);
        for (int i = 0; i < 9000 && BUSY !== 1'b0; i++) begin
            @(posedge MCLK);
            #1;
        end
        chk("stopped", BUSY, 0);
        repeat (4) @(posedge MCLK);
        #1;
        chk("idle", req, 0);
        chk("fails", nf, k);
        chk("done", nd, k == 0);
        chk("addr", fa, k ? 2 : 0);
        chk("good", fg, g);
        chk("bad", fb, b);
        chk("seq", fs, q);
        $display("test single %0d done", f);
    endtask : t_once
    task t_loop(input logic [1:0] f, input int k, input logic [15:0] g, b, input logic [7:0] q);
        stuck <= 1;
        go(f);
        chk("clear", pc, 0);
        for (int i = 0; i < 20000 && ns < 2; i++) begin
            @(posedge MCLK);
            #1;
        end
        chk("fails", nf, 2 * k);
        chk("count", pc, 2);
        chk("good", fg, g);
        chk("bad", fb, b);
        chk("seq", fs, q);
        chk("looping", BUSY, 1);
        @(posedge MCLK);
        RESET_REQ <= 1;
        @(posedge MCLK);
        RESET_REQ <= 0;
        #1;
        chk("ended", BUSY, 0);
        repeat (3) @(posedge MCLK);
        #1;
        chk("halted", req, 0);
        $display("test loop %0d done", f);
    endtask : t_loop
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge MCLK);
        SRST <= 0;
        t_refuse;
        t_once(2'h0, 0, 0, 16'h0, 16'h0, 8'h0);
        t_once(2'h0, 1, 15, 16'hFFFE, 16'hFFFF, 8'h0);
        t_once(2'h1, 1, 2, 16'hAAAA, 16'hAAAB, 8'h04);
        t_loop(2'h2, 15, 16'hFFFE, 16'hFFFF, 8'h0);
        t_loop(2'h3, 2, 16'hAAAA, 16'hAAAB, 8'h04);
        give_verdict;
    end
endmodule : target_ram_test_engine_bench
`default_nettype wire
